// [spef_consts.vh]
// Constants for the serial EEPROM front end: states, counts, fill values.
// Assumes inclusion by the front end, which passes the FIFO sizes on as parameters; definitions only.
// Notes on behaviour
// - Serial input bit is captured on each rising edge of the serial clock.
// - While sending, the output bit changes on each falling serial clock edge.
// - Select high means deselected, and the serial output stays undriven.
// - Select low makes the device selected and active.
// - After power-up nothing is accepted until a select falling edge is seen.
// - Pause suspends the transfer without deselecting; it resumes afterwards.
// - During pause the output is undriven; input and clock are ignored.
// - Write-protect freezes the two protect-size bits against writes.
// - Instruction, address and input data arrive most significant bit first.
// - Every output byte leaves most significant bit first.
// - The first input bit is taken on the first rising edge after select falls.
// - Read-type commands drive the first bit on the first falling edge after them.
// - An unknown command drops to standby, output undriven, until select rises.
// - A known command stays active until select rises.
// - Clock modes 0 and 3 both work; sample on rise, shift on fall.
`ifndef SPEF_CONSTS_VH
`define SPEF_CONSTS_VH
`define SPEF_BYTE_W 8
`define SPEF_BIT_LAST 3'h7
`define SPEF_BIT_FIRST 3'h0
`define SPEF_FILL_BYTE 8'hFF
`define SPEF_FIFO_W 8
`define SPEF_FIFO_D 4
`define SPEF_FIFO_AW 2
`define SPEF_ST_W 3
`define SPEF_ST_IDLE 3'h0
`define SPEF_ST_CMD 3'h1
`define SPEF_ST_CHECK 3'h2
`define SPEF_ST_ACTIVE 3'h3
`define SPEF_ST_STANDBY 3'h4
`endif

// [spef_fifo.v]
// Small FIFO with a registered output word, valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset shared with its user.
`timescale 1ns/1ps
module spef_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Filling side
  input wire wr_valid_in,
  input wire [W-1:0] wr_data_in,
  output wire wr_ready_out,
  // Draining side
  input wire rd_ready_in,
  output reg rd_valid_out,
  output reg [W-1:0] rd_data_out
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire full = (cnt_q == D[AW:0]);
  wire push = wr_valid_in && !full;
  wire fill = (cnt_q != {(AW+1){1'b0}}) && (!rd_valid_out || rd_ready_in);

  assign wr_ready_out = !full;

  // Storage array, no reset needed for data
  always @(posedge clk_in) begin
    if (push) begin
      mem[wp_q] <= wr_data_in;
    end
  end

  // Pointers, count and output register
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out <= {W{1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (fill) begin
        rd_data_out <= mem[rp_q];
        rd_valid_out <= 1'b1;
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
      // Count moves by push minus fill
      if (push && !fill) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (fill && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [spef_front_end.v]
// Serial slave front end of a small EEPROM: selection, shifting, pause, protect.
// Assumes the master's pins arrive asynchronously and the clock is well over
// six times the serial clock; the command decoder sits outside on clk_in.
`timescale 1ns/1ps
`include "spef_consts.vh"
module spef_front_end (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Serial pins from the master
  input wire sel_n_in,
  input wire sclk_in,
  input wire sdi_in,
  input wire pause_n_in,
  input wire wp_n_in,
  // Serial output pin, three-state split
  output reg sdo_out,
  output reg sdo_oe_out,
  // Command byte to the decoder
  output reg [7:0] cmd_byte_out,
  output reg cmd_strobe_out,
  input wire cmd_ok_in,
  input wire cmd_read_in,
  // Received address and data bytes
  output wire rx_valid_out,
  output wire [7:0] rx_data_out,
  input wire rx_ready_in,
  output reg rx_overrun_out,
  // Bytes to send on reads
  input wire tx_valid_in,
  input wire [7:0] tx_data_in,
  output reg tx_ready_out,
  // Protect-size bits
  input wire protect_wr_in,
  input wire protect_size_hi_in,
  input wire protect_size_lo_in,
  output reg protect_size_hi_out,
  output reg protect_size_lo_out,
  // Status
  output reg selected_out,
  output reg active_out,
  output reg frame_end_out
);
  // Synchroniser stages for the pins
  reg sel_s1_q, sel_s2_q, sel_s3_q;
  reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg sdi_s1_q, sdi_s2_q;
  reg pause_s1_q, pause_s2_q;
  reg wp_s1_q, wp_s2_q;
  // Link state
  reg [`SPEF_ST_W-1:0] st_q;
  reg armed_q;
  reg [2:0] bit_q;
  reg [7:0] rx_sh_q;
  reg sending_q;
  reg first_fall_q;
  reg [7:0] tx_sh_q;
  reg [7:0] tx_hold_q;
  reg tx_full_q;
  reg push_q;
  reg [7:0] push_data_q;
  wire fifo_ready;

  // Decoded pin events, all from settled stages
  wire sel_fall = sel_s3_q && !sel_s2_q;
  wire sel_rise = !sel_s3_q && sel_s2_q;
  wire sel_low = !sel_s2_q;
  wire paused = sel_low && !pause_s2_q;
  // Edges from stages two and three, so each pin edge is seen once
  wire sck_rise = sclk_s2_q && !sclk_s3_q;
  wire sck_fall = !sclk_s2_q && sclk_s3_q;
  // Pause gates every edge; counters and shifters just wait it out
  wire live = armed_q && sel_low && !paused;
  wire byte_done = live && sck_rise && (bit_q == `SPEF_BIT_LAST);
  wire [7:0] rx_next = {rx_sh_q[6:0], sdi_s2_q};

  // Two-flop synchronisers; reset low so a held-low select shows no fall
  // Pause resets high, its idle level, so reset shows no false pause
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      sel_s3_q <= 1'b0;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
      pause_s1_q <= 1'b1;
      pause_s2_q <= 1'b1;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      sel_s1_q <= sel_n_in;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sclk_s1_q <= sclk_in;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdi_s1_q <= sdi_in;
      sdi_s2_q <= sdi_s1_q;
      pause_s1_q <= pause_n_in;
      pause_s2_q <= pause_s1_q;
      wp_s1_q <= wp_n_in;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Power-up gate: nothing counts before the first select fall
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      armed_q <= 1'b0;
    end else if (sel_fall) begin
      armed_q <= 1'b1;
    end
  end

  // Bit counter and input shifter, MSB first on rising edges
  // Standby ignores input, so the counter freezes until deselect
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      bit_q <= `SPEF_BIT_FIRST;
      rx_sh_q <= 8'h00;
    end else if (sel_fall || sel_rise) begin
      bit_q <= `SPEF_BIT_FIRST;
      rx_sh_q <= 8'h00;
    end else if (live && sck_rise && st_q != `SPEF_ST_STANDBY) begin
      rx_sh_q <= rx_next;
      bit_q <= bit_q + 3'h1;
    end
  end

  // Link state machine
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q <= `SPEF_ST_IDLE;
      sending_q <= 1'b0;
      cmd_byte_out <= 8'h00;
      cmd_strobe_out <= 1'b0;
    end else begin
      cmd_strobe_out <= 1'b0;
      if (sel_rise || !sel_low) begin
        st_q <= `SPEF_ST_IDLE;
        sending_q <= 1'b0;
      end else if (sel_fall) begin
        // A fresh selection always restarts instruction decoding
        st_q <= `SPEF_ST_CMD;
        sending_q <= 1'b0;
      end else begin
        case (st_q)
          `SPEF_ST_CMD: begin
            if (byte_done) begin
              cmd_byte_out <= rx_next;
              cmd_strobe_out <= 1'b1;
              st_q <= `SPEF_ST_CHECK;
            end
          end
          `SPEF_ST_CHECK: begin
            // Decoder answers in the cycle after the strobe
            if (!cmd_strobe_out) begin
              if (cmd_ok_in) begin
                st_q <= `SPEF_ST_ACTIVE;
                sending_q <= cmd_read_in;
              end else begin
                st_q <= `SPEF_ST_STANDBY;
              end
            end
          end
          `SPEF_ST_ACTIVE: begin
            st_q <= `SPEF_ST_ACTIVE;
          end
          `SPEF_ST_STANDBY: begin
            st_q <= `SPEF_ST_STANDBY;
          end
          default: begin
            st_q <= `SPEF_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Pending byte for the sender, refilled from the user side
  // Ready is a flop, cleared on the same edge as each take
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= !tx_full_q && !(tx_valid_in && tx_ready_out);
      if (tx_valid_in && tx_ready_out) begin
        tx_hold_q <= tx_data_in;
        tx_full_q <= 1'b1;
      end else if (sending_q && first_fall_q && live && sck_fall) begin
        tx_full_q <= 1'b0;
      end else if (!sel_low) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // Output shifter; an empty holder sends the fill byte
  // First fall of each byte loads the shifter from the holder; later falls shift it
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      first_fall_q <= 1'b0;
      tx_sh_q <= 8'h00;
      sdo_out <= 1'b0;
    end else if (!sel_low) begin
      first_fall_q <= 1'b0;
    end else begin
      if (st_q == `SPEF_ST_CHECK || byte_done) begin
        first_fall_q <= 1'b1;
      end
      if (sending_q && live && sck_fall) begin
        first_fall_q <= 1'b0;
        if (first_fall_q) begin
          // Put the byte's MSB out now and load the seven bits after it
          tx_sh_q <= tx_full_q ? {tx_hold_q[6:0], 1'b0} : `SPEF_FILL_BYTE;
          sdo_out <= tx_full_q ? tx_hold_q[7] : 1'b1;
        end else begin
          sdo_out <= tx_sh_q[7];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Output enable: only while selected, sending, active and not paused
  // It turns on at a seen fall, with the bit, so no stale bit leads
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      sdo_oe_out <= 1'b0;
    end else begin
      // Once on, it stays on until pause, deselect or standby
      sdo_oe_out <= sending_q && live && (st_q == `SPEF_ST_ACTIVE) &&
        (sdo_oe_out || sck_fall);
    end
  end

  // Address and data bytes go to the FIFO; a full FIFO loses the byte
  // The instruction byte is never pushed; only the bytes after it
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      push_q <= 1'b0;
      push_data_q <= 8'h00;
      rx_overrun_out <= 1'b0;
    end else begin
      push_q <= 1'b0;
      if (byte_done && st_q == `SPEF_ST_ACTIVE) begin
        if (fifo_ready) begin
          push_q <= 1'b1;
          push_data_q <= rx_next;
        end else begin
          rx_overrun_out <= 1'b1;
        end
      end else if (sel_fall) begin
        rx_overrun_out <= 1'b0;
      end
    end
  end

  // Protect size frozen while write-protect is low
  // Locked bits keep the protected region's size fixed for writes
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      protect_size_hi_out <= 1'b0;
      protect_size_lo_out <= 1'b0;
    end else if (protect_wr_in && wp_s2_q) begin
      protect_size_hi_out <= protect_size_hi_in;
      protect_size_lo_out <= protect_size_lo_in;
    end
  end

  // Status outputs
  // Frame end pulses once per selection, and only after arming
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      selected_out <= 1'b0;
      active_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      selected_out <= armed_q && sel_low;
      active_out <= armed_q && sel_low && st_q != `SPEF_ST_STANDBY;
      frame_end_out <= sel_rise && armed_q;
    end
  end

  // Receive FIFO; push waits one cycle so a held byte is still taken
  // Four words and the output register ride out a short consumer stall
  spef_fifo #(
    .W(`SPEF_FIFO_W),
    .D(`SPEF_FIFO_D),
    .AW(`SPEF_FIFO_AW)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_valid_in(push_q),
    .wr_data_in(push_data_q),
    .wr_ready_out(fifo_ready),
    .rd_ready_in(rx_ready_in),
    .rd_valid_out(rx_valid_out),
    .rd_data_out(rx_data_out)
  );
endmodule

// [spef_front_end_chk.sv]
// Port checker for the serial front end.
// Assumes a bind onto spef_front_end and one clock domain.
`timescale 1ns/1ps
module spef_front_end_chk (
  // Clock, reset and pins
  input wire clk_in, nrst_in, sel_n_in, sclk_in, pause_n_in, wp_n_in,
  // Outputs watched
  input wire sdo_out, sdo_oe_out, cmd_strobe_out, rx_overrun_out,
  input wire protect_size_hi_out, protect_size_lo_out,
  input wire selected_out, active_out, frame_end_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Four cycles of sync lag allowed before the pin counts
  a_desel_hiz: assert property (sel_n_in [*5] |-> !sdo_oe_out)
    else $error("output driven while deselected");
  a_desel_off: assert property (sel_n_in [*5] |-> !selected_out)
    else $error("selected while select high");
  a_pause_hiz: assert property (!pause_n_in [*5] |-> !sdo_oe_out)
    else $error("output driven during pause");
  a_strobe_sel: assert property (cmd_strobe_out |-> selected_out)
    else $error("instruction taken while not selected");
  a_active_sel: assert property (active_out |-> selected_out)
    else $error("active without selection");
  // Loose window: the fall is seen three to six cycles late
  a_sdo_fall: assert property ($changed(sdo_out) && sdo_oe_out && $past(sdo_oe_out)
    |-> !$past(sclk_in, 3) && $past(sclk_in, 7))
    else $error("output bit moved off a falling edge");
  a_oe_first: assert property ($rose(sdo_oe_out)
    |-> active_out && !$past(sclk_in, 3) && $past(sclk_in, 7))
    else $error("first output bit not on a falling edge");
  a_protect_hold: assert property (!wp_n_in [*4]
    |=> $stable({protect_size_hi_out, protect_size_lo_out}))
    else $error("protect bits moved while locked");
  a_frame_close: assert property (frame_end_out
    |-> $past(sel_n_in, 2) ##1 !frame_end_out && !active_out)
    else $error("frame end without select rise");
  c_strobe: cover property (cmd_strobe_out);
  c_sending: cover property ($rose(sdo_oe_out));
  c_overrun: cover property ($rose(rx_overrun_out));
endmodule
bind spef_front_end spef_front_end_chk chk (.clk_in, .nrst_in, .sel_n_in, .sclk_in,
  .pause_n_in, .wp_n_in, .sdo_out, .sdo_oe_out, .cmd_strobe_out, .rx_overrun_out,
  .protect_size_hi_out, .protect_size_lo_out, .selected_out, .active_out, .frame_end_out);

// [spef_front_end_tb.sv]
// Self-checking bench for the serial front end.
// Assumes spef_master_model and the 50 MHz system clock.
`timescale 1ns/1ps
module spef_front_end_tb;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg rx_ready_in = 1'b0;
  reg tx_valid_in = 1'b0;
  reg [7:0] tx_data_in = 8'hC6;
  reg protect_wr_in = 1'b0;
  reg protect_size_hi_in = 1'b1;
  reg protect_size_lo_in = 1'b0;
  wire sel_n_in, sclk_in, sdi_in, pause_n_in, wp_n_in, sdo_out, sdo_oe_out;
  wire cmd_strobe_out, rx_valid_out, rx_overrun_out, tx_ready_out, frame_end_out;
  wire protect_size_hi_out, protect_size_lo_out, selected_out, active_out;
  wire [7:0] cmd_byte_out, rx_data_out;
  wire sdo_line = sdo_oe_out ? sdo_out : 1'bz;
  // Decoder stand-in: E7 unknown, 03 reads
  wire cmd_ok_in = cmd_byte_out !== 8'hE7;
  wire cmd_read_in = cmd_byte_out === 8'h03;
  integer failures = 0, num_checks = 0, strobes = 0;
  reg [7:0] last_cmd = 8'h00, r;
  reg [7:0] rxq [$];
  always #10 clk_in = ~clk_in;
  spef_master_model m (.clk_in, .sel_n_out(sel_n_in), .sclk_out(sclk_in),
    .sdi_out(sdi_in), .pause_n_out(pause_n_in), .wp_n_out(wp_n_in), .sdo_in(sdo_line));
  spef_front_end dut (.clk_in, .nrst_in, .sel_n_in, .sclk_in, .sdi_in, .pause_n_in,
    .wp_n_in, .sdo_out, .sdo_oe_out, .cmd_byte_out, .cmd_strobe_out, .cmd_ok_in,
    .cmd_read_in, .rx_valid_out, .rx_data_out, .rx_ready_in, .rx_overrun_out,
    .tx_valid_in, .tx_data_in, .tx_ready_out, .protect_wr_in, .protect_size_hi_in,
    .protect_size_lo_in, .protect_size_hi_out, .protect_size_lo_out, .selected_out,
    .active_out, .frame_end_out);
  // Instruction and received-byte logs
  always @(posedge clk_in) begin
    if (cmd_strobe_out === 1'b1) begin
      strobes <= strobes + 1;
      last_cmd <= cmd_byte_out;
    end
    if (rx_valid_out === 1'b1 && rx_ready_in) rxq.push_back(rx_data_out);
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Protect pulse on the bench's falling edge
  task prot(input hi, input lo);
    begin
      protect_size_hi_in = hi;
      protect_size_lo_in = lo;
      protect_wr_in = 1'b1;
      m.hold(1);
      protect_wr_in = 1'b0;
      m.hold(3);
    end
  endtask
  initial begin : seq
    integer i;
    m.hold(5);
    nrst_in = 1'b1;
    m.xfer(8'h02, 8, r);
    m.stop;
    chk(strobes[7:0], 8'h00);
    $display("test power-up done");
    // Consumer stalled: FIFO fills until bytes are lost
    m.start;
    m.xfer(8'h02, 8, r);
    for (i = 0; i < 6; i = i + 1) m.xfer(8'h11 + i[7:0], 8, r);
    m.stop;
    chk(last_cmd, 8'h02);
    chk({7'h00, rx_overrun_out}, 8'h01);
    rx_ready_in = 1'b1;
    m.hold(20);
    chk(rxq[0], 8'h11);
    chk(rxq[4], 8'h15);
    chk({7'h00, rx_valid_out}, 8'h00);
    $display("test write done");
    rxq.delete();
    m.start;
    m.xfer(8'h02, 8, r);
    m.xfer(8'hA5, 4, r);
    m.pause;
    m.xfer(8'h50, 4, r);
    m.stop;
    chk(rxq[0], 8'hA5);
    $display("test pause done");
    m.start;
    m.xfer(8'hFF, 3, r);
    m.stop;
    m.start;
    m.xfer(8'h3C, 8, r);
    m.stop;
    chk(last_cmd, 8'h3C);
    $display("test partial done");
    m.cpol = 1'b1;
    tx_valid_in = 1'b1;
    m.start;
    m.xfer(8'h03, 8, r);
    m.xfer(8'h00, 4, r);
    chk(r, 8'hC0);
    m.pause;
    m.xfer(8'h00, 4, r);
    chk(r, 8'h60);
    m.xfer(8'h00, 8, r);
    m.stop;
    chk(r, 8'hC6);
    tx_valid_in = 1'b0;
    m.hold(2);
    chk({7'h00, tx_ready_out}, 8'h01);
    $display("test read done");
    m.cpol = 1'b0;
    rxq.delete();
    m.start;
    m.xfer(8'hE7, 8, r);
    m.xfer(8'h55, 8, r);
    chk({selected_out, active_out, sdo_oe_out}, 8'h04);
    m.stop;
    chk(rxq.size(), 8'h00);
    $display("test unknown done");
    prot(1'b1, 1'b0);
    chk({protect_size_hi_out, protect_size_lo_out}, 8'h02);
    m.wp_n_out = 1'b0;
    m.hold(4);
    prot(1'b0, 1'b1);
    chk({protect_size_hi_out, protect_size_lo_out}, 8'h02);
    $display("test protect done");
    give_verdict;
  end
  // Run needs about 25 us
  initial begin
    #500000;
    failures = failures + 1;
    give_verdict;
  end
endmodule

// [spef_master_model.sv]
// Serial master model driving the front end's pins.
// Assumes the bench clock; tasks are called from the bench.
`timescale 1ns/1ps
module spef_master_model (
  // Bench clock
  input wire clk_in,
  // Pins toward the device
  output reg sel_n_out, sclk_out, sdi_out, pause_n_out, wp_n_out,
  // Resolved serial output line
  input wire sdo_in
);
  reg cpol = 1'b0;
  // Select low at power-up gives no falling edge
  initial begin
    sel_n_out = 1'b0;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    pause_n_out = 1'b1;
    wp_n_out = 1'b1;
  end
  // Pins change only at the falling clock edge
  task hold(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  // Clock parked at its idle level before select falls
  task start;
    begin
      sclk_out = cpol;
      hold(4);
      sel_n_out = 1'b0;
      hold(4);
    end
  endtask
  // n bits MSB first; read back at the end of each high phase
  task xfer(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        sclk_out = 1'b0;
        sdi_out = tx[i];
        hold(4);
        sclk_out = 1'b1;
        hold(4);
        rx[i] = sdo_in;
      end
    end
  endtask
  // Released data line flips so a stale bit cannot pass
  task stop;
    begin
      sclk_out = cpol;
      hold(4);
      sel_n_out = 1'b1;
      sdi_out = ~sdi_out;
      hold(8);
    end
  endtask
  // Junk clock and data while paused, selected throughout
  task pause;
    begin
      pause_n_out = 1'b0;
      hold(4);
      sclk_out = 1'b0;
      sdi_out = ~sdi_out;
      hold(4);
      sclk_out = 1'b1;
      hold(4);
      pause_n_out = 1'b1;
      hold(4);
    end
  endtask
endmodule
